// ===== pkg/dsp_defs.vh
// register map, field layout, reset values and decodes of the drive source select parameter bank
// Notes on behaviour
// - The low four bits of the display format word give the decimal places, 0 to 3.
// - Bits 4 to 15 of the display format word hold a unit code from 0x000 (hertz) to 0x024 (cubic feet per minute).
// - A user maximum of zero turns user scaling off, otherwise the raw maximum spans 1 to 65535.
// - The user maximum is read with the selected decimal places, giving 65535, 6553.5, 655.35 or 65.535 at most.
// - Local/remote selection 0 applies standard hand-off-auto switching.
// - Local/remote selection 1 stops the drive on every local/remote switch.
// - Local/remote selection 2 keeps running on a switch with the remote frequency and run settings.
// - Local/remote selection 3 keeps running on a switch with the local frequency and run settings.
// - Local/remote selection 4, the default, follows whichever side was switched to.
// - The hand frequency source decodes 0,1,2,3,4,7,8,9 to keypad, RS-485, analog, up/down, pulse, pot, card, PID.
// - The hand run source decodes 0 keypad, 1 terminals, 2 RS-485, 5 card; 3 is unused.
// - The stop-key setting ignores the keypad stop key at 0 and acts on it at 1.
// - Auxiliary source 0 disables combining; 1 to 8 select keypad, RS-485, analog, up/down, pulse, unused, pot, card.
// - Combining gives master plus aux at 0, master minus aux at 1, aux minus master at 2.
// - Both display filter times accept 1 to 65535 milliseconds and reset to 100 milliseconds.
`ifndef DSP_DEFS_VH
`define DSP_DEFS_VH

`define DSP_MB_REF_BASE 40001
`define DSP_ADDR_W 16
`define DSP_DATA_W 16

`define DSP_OFS_FREQ_MEM 16'h0018
`define DSP_OFS_DISP_FMT 16'h0019
`define DSP_OFS_USER_MAX 16'h001A
`define DSP_OFS_USER_VAL 16'h001B
`define DSP_OFS_LR_MODE 16'h001D
`define DSP_OFS_HAND_FSRC 16'h001E
`define DSP_OFS_HAND_RSRC 16'h001F
`define DSP_OFS_STOP_KEY 16'h0020
`define DSP_OFS_AUX_SRC 16'h0023
`define DSP_OFS_COMBINE 16'h0024
`define DSP_OFS_FILT_CUR 16'h0030
`define DSP_OFS_FILT_KPD 16'h0031
`define DSP_OFS_FW_DATE 16'h0032

`define DSP_RST_FREQ_MEM 16'h003C
`define DSP_RST_DISP_FMT 16'h0000
`define DSP_RST_USER_MAX 16'h0000
`define DSP_RST_LR_MODE 16'h0004
`define DSP_RST_HAND_FSRC 16'h0000
`define DSP_RST_HAND_RSRC 16'h0000
`define DSP_RST_STOP_KEY 16'h0000
`define DSP_RST_AUX_SRC 16'h0000
`define DSP_RST_COMBINE 16'h0000
`define DSP_RST_FILT 16'h0064
`define DSP_FILT_MIN 16'h0001

`define DSP_DEC_LSB 0
`define DSP_DEC_MSB 3
`define DSP_DEC_MAX 4'h3
`define DSP_UNIT_LSB 4
`define DSP_UNIT_MSB 15
`define DSP_UNIT_MAX 12'h024

`define DSP_LR_HOA 16'h0000
`define DSP_LR_STOP 16'h0001
`define DSP_LR_REMOTE 16'h0002
`define DSP_LR_LOCAL 16'h0003
`define DSP_LR_FOLLOW 16'h0004

`define DSP_FSRC_MAX 16'h0009
`define DSP_FSRC_UNUSED5 16'h0005
`define DSP_RSRC_MAX 16'h0005
`define DSP_RSRC_UNUSED4 16'h0004
`define DSP_STOP_MAX 16'h0001
`define DSP_AUX_MAX 16'h0008
`define DSP_COMB_MAX 16'h0002

`define DSP_SRC_W 4
`define DSP_FREQ_W 16

`endif

// ===== design/dsp_param_reg.v
// one 16-bit read/write parameter with range check on write
module dsp_param_reg #(
	parameter W = 16,
	parameter [W-1:0] RST = {W{1'b0}},
	parameter [W-1:0] LO = {W{1'b0}},
	parameter [W-1:0] HI = {W{1'b1}},
	parameter [W-1:0] HOLE = {W{1'b1}},
	parameter USE_HOLE = 0
) (
	input wire clk,
	input wire rst_n,
	input wire wr,
	input wire [W-1:0] wdata,
	output reg [W-1:0] value_q,
	output wire ok
);
	wire lo_ok;
	wire hi_ok;
	wire hole_ok;
	// bounds at the ends of the word range are left out so that no compare is constant
	generate
		if (LO == {W{1'b0}}) begin : g_lo_open
			assign lo_ok = 1'b1;
		end else begin : g_lo_chk
			assign lo_ok = (wdata >= LO);
		end
		if (HI == {W{1'b1}}) begin : g_hi_open
			assign hi_ok = 1'b1;
		end else begin : g_hi_chk
			assign hi_ok = (wdata <= HI);
		end
		if (USE_HOLE != 0) begin : g_hole_chk
			assign hole_ok = (wdata != HOLE);
		end else begin : g_hole_open
			assign hole_ok = 1'b1;
		end
	endgenerate
	assign ok = lo_ok && hi_ok && hole_ok;
	always @(posedge clk) begin
		if (!rst_n) begin
			value_q <= RST;
		end else if (wr && ok) begin
			value_q <= wdata;
		end
	end
endmodule // dsp_param_reg

// ===== design/dsp_source_select.v
// parameter bank: display format, user scaling, local/remote handling, source selectors, combining
`include "dsp_defs.vh"
module dsp_source_select #(
	parameter [15:0] FW_DATE = 16'h0000
) (
	input wire CLOCK,
	input wire RESET_N,
	input wire REG_WR,
	input wire REG_RD,
	input wire [15:0] REG_ADDR,
	input wire [15:0] REG_WDATA,
	output reg [15:0] REG_RDATA,
	output reg REG_ACK,
	output reg REG_ERR,
	input wire [15:0] FREQ_MEM_IN,
	input wire [15:0] PROC_VALUE,
	input wire REMOTE_SEL,
	input wire STOP_KEY,
	input wire [15:0] FREQ_KEYPAD,
	input wire [15:0] FREQ_RS485,
	input wire [15:0] FREQ_ANALOG,
	input wire [15:0] FREQ_UPDOWN,
	input wire [15:0] FREQ_PULSE,
	input wire [15:0] FREQ_POT,
	input wire [15:0] FREQ_CARD,
	input wire [15:0] FREQ_PID,
	input wire [15:0] FREQ_REMOTE,
	input wire [1:0] RUN_LOCAL,
	input wire [1:0] RUN_REMOTE,
	output reg [15:0] FREQ_CMD,
	output reg [1:0] RUN_CMD,
	output reg DRIVE_STOP,
	output reg [3:0] DEC_PLACES,
	output reg [11:0] UNIT_CODE,
	output reg SCALE_EN,
	output reg [15:0] SCALE_MAX,
	output reg [15:0] FILT_CUR,
	output reg [15:0] FILT_KPD
);
	wire [15:0] fmt_q, umax_q, lr_q, fsrc_q, rsrc_q, stop_q, aux_q, comb_q, fcur_q, fkpd_q;
	wire umax_ok, lr_ok, fsrc_ok, rsrc_ok, stop_ok, aux_ok, comb_ok, fcur_ok, fkpd_ok;
	reg [15:0] freq_mem_q, user_val_q;
	reg [2:0] rem_sync_q;
	reg remote_q, local_run_en;
	reg [15:0] master_f, aux_f, comb_f, local_f, rd_mux;
	reg [16:0] sum_f;
	reg rd_hit, wr_hit, wr_ok;
	wire is_wr = REG_WR;
	wire wr_fmt = is_wr && (REG_ADDR == `DSP_OFS_DISP_FMT);
	wire wr_umax = is_wr && (REG_ADDR == `DSP_OFS_USER_MAX);
	wire wr_lr = is_wr && (REG_ADDR == `DSP_OFS_LR_MODE);
	wire wr_fsrc = is_wr && (REG_ADDR == `DSP_OFS_HAND_FSRC);
	wire wr_rsrc = is_wr && (REG_ADDR == `DSP_OFS_HAND_RSRC);
	wire wr_stop = is_wr && (REG_ADDR == `DSP_OFS_STOP_KEY);
	wire wr_aux = is_wr && (REG_ADDR == `DSP_OFS_AUX_SRC);
	wire wr_comb = is_wr && (REG_ADDR == `DSP_OFS_COMBINE);
	wire wr_fcur = is_wr && (REG_ADDR == `DSP_OFS_FILT_CUR);
	wire wr_fkpd = is_wr && (REG_ADDR == `DSP_OFS_FILT_KPD);
	wire fmt_good = (REG_WDATA[`DSP_DEC_MSB:`DSP_DEC_LSB] <= `DSP_DEC_MAX) &&
		(REG_WDATA[`DSP_UNIT_MSB:`DSP_UNIT_LSB] <= `DSP_UNIT_MAX);

	// decimal places in low nibble, unit code above
	dsp_param_reg #(.RST(`DSP_RST_DISP_FMT)) u_fmt (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_fmt && fmt_good),
		.wdata(REG_WDATA), .value_q(fmt_q), .ok());
	dsp_param_reg #(.RST(`DSP_RST_USER_MAX)) u_umax (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_umax),
		.wdata(REG_WDATA), .value_q(umax_q), .ok(umax_ok));
	dsp_param_reg #(.RST(`DSP_RST_LR_MODE), .HI(`DSP_LR_FOLLOW)) u_lr (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_lr),
		.wdata(REG_WDATA), .value_q(lr_q), .ok(lr_ok));
	dsp_param_reg #(.RST(`DSP_RST_HAND_FSRC), .HI(`DSP_FSRC_MAX), .HOLE(`DSP_FSRC_UNUSED5), .USE_HOLE(1)) u_fsrc (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_fsrc),
		.wdata(REG_WDATA), .value_q(fsrc_q), .ok(fsrc_ok));
	dsp_param_reg #(.RST(`DSP_RST_HAND_RSRC), .HI(`DSP_RSRC_MAX), .HOLE(`DSP_RSRC_UNUSED4), .USE_HOLE(1)) u_rsrc (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_rsrc),
		.wdata(REG_WDATA), .value_q(rsrc_q), .ok(rsrc_ok));
	dsp_param_reg #(.RST(`DSP_RST_STOP_KEY), .HI(`DSP_STOP_MAX)) u_stop (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_stop),
		.wdata(REG_WDATA), .value_q(stop_q), .ok(stop_ok));
	dsp_param_reg #(.RST(`DSP_RST_AUX_SRC), .HI(`DSP_AUX_MAX)) u_aux (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_aux),
		.wdata(REG_WDATA), .value_q(aux_q), .ok(aux_ok));
	dsp_param_reg #(.RST(`DSP_RST_COMBINE), .HI(`DSP_COMB_MAX)) u_comb (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_comb),
		.wdata(REG_WDATA), .value_q(comb_q), .ok(comb_ok));
	dsp_param_reg #(.RST(`DSP_RST_FILT), .LO(`DSP_FILT_MIN)) u_fcur (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_fcur),
		.wdata(REG_WDATA), .value_q(fcur_q), .ok(fcur_ok));
	dsp_param_reg #(.RST(`DSP_RST_FILT), .LO(`DSP_FILT_MIN)) u_fkpd (
		.clk(CLOCK), .rst_n(RESET_N), .wr(wr_fkpd),
		.wdata(REG_WDATA), .value_q(fkpd_q), .ok(fkpd_ok));

	// holding register address decode and write acceptance
	always @* begin
		rd_hit = 1'b1;
		rd_mux = 16'h0000;
		wr_hit = 1'b1;
		wr_ok = 1'b0;
		case (REG_ADDR)
			`DSP_OFS_FREQ_MEM: begin
				rd_mux = freq_mem_q;
				wr_ok = 1'b0;
			end
			`DSP_OFS_DISP_FMT: begin
				rd_mux = fmt_q;
				wr_ok = fmt_good;
			end
			`DSP_OFS_USER_MAX: begin
				rd_mux = umax_q;
				wr_ok = umax_ok;
			end
			`DSP_OFS_USER_VAL: begin
				rd_mux = user_val_q;
				wr_ok = 1'b0;
			end
			`DSP_OFS_LR_MODE: begin
				rd_mux = lr_q;
				wr_ok = lr_ok;
			end
			`DSP_OFS_HAND_FSRC: begin
				rd_mux = fsrc_q;
				wr_ok = fsrc_ok;
			end
			`DSP_OFS_HAND_RSRC: begin
				rd_mux = rsrc_q;
				wr_ok = rsrc_ok;
			end
			`DSP_OFS_STOP_KEY: begin
				rd_mux = stop_q;
				wr_ok = stop_ok;
			end
			`DSP_OFS_AUX_SRC: begin
				rd_mux = aux_q;
				wr_ok = aux_ok;
			end
			`DSP_OFS_COMBINE: begin
				rd_mux = comb_q;
				wr_ok = comb_ok;
			end
			`DSP_OFS_FILT_CUR: begin
				rd_mux = fcur_q;
				wr_ok = fcur_ok;
			end
			`DSP_OFS_FILT_KPD: begin
				rd_mux = fkpd_q;
				wr_ok = fkpd_ok;
			end
			`DSP_OFS_FW_DATE: begin
				rd_mux = FW_DATE;
				wr_ok = 1'b0;
			end
			default: begin
				rd_hit = 1'b0;
				wr_hit = 1'b0;
			end
		endcase
	end

	// an unmapped read, a refused value or a read-only target all answer with the error flag
	wire rd_err = REG_RD && !rd_hit;
	wire wr_err = REG_WR && !(wr_hit && wr_ok);

	always @(posedge CLOCK) begin
		if (!RESET_N) begin
			REG_RDATA <= 16'h0000;
			REG_ACK <= 1'b0;
			REG_ERR <= 1'b0;
		end else begin
			REG_ACK <= REG_RD || REG_WR;
			REG_ERR <= rd_err || wr_err;
			REG_RDATA <= (REG_RD && rd_hit) ? rd_mux : 16'h0000;
		end
	end

	// read-only status words are captured from drive state, never from the bus
	always @(posedge CLOCK) begin
		if (!RESET_N) begin
			freq_mem_q <= `DSP_RST_FREQ_MEM;
			user_val_q <= 16'h0000;
		end else begin
			freq_mem_q <= FREQ_MEM_IN;
			user_val_q <= (umax_q == 16'h0000) ? 16'h0000 : PROC_VALUE;
		end
	end

	// local/remote pin synchroniser, change counts once stages two and three agree
	always @(posedge CLOCK) begin
		if (!RESET_N) begin
			rem_sync_q <= 3'h0;
			remote_q <= 1'b0;
		end else begin
			rem_sync_q <= {rem_sync_q[1:0], REMOTE_SEL};
			if (rem_sync_q[1] == rem_sync_q[2]) begin
				remote_q <= rem_sync_q[2];
			end
		end
	end
	wire lr_switch = (rem_sync_q[1] == rem_sync_q[2]) && (rem_sync_q[2] != remote_q);

	// hand frequency and auxiliary source selection
	always @* begin
		case (fsrc_q[3:0])
			4'h0: master_f = FREQ_KEYPAD;
			4'h1: master_f = FREQ_RS485;
			4'h2: master_f = FREQ_ANALOG;
			4'h3: master_f = FREQ_UPDOWN;
			4'h4: master_f = FREQ_PULSE;
			4'h7: master_f = FREQ_POT;
			4'h8: master_f = FREQ_CARD;
			4'h9: master_f = FREQ_PID;
			default: master_f = 16'h0000;
		endcase
		case (aux_q[3:0])
			4'h1: aux_f = FREQ_KEYPAD;
			4'h2: aux_f = FREQ_RS485;
			4'h3: aux_f = FREQ_ANALOG;
			4'h4: aux_f = FREQ_UPDOWN;
			4'h5: aux_f = FREQ_PULSE;
			4'h7: aux_f = FREQ_POT;
			4'h8: aux_f = FREQ_CARD;
			default: aux_f = 16'h0000;
		endcase
		// the sum wraps at the word width; the two differences clamp at zero
		sum_f = master_f + aux_f;
		if (aux_q == 16'h0000) begin
			comb_f = master_f;
		end else begin
			case (comb_q[1:0])
				2'h0: comb_f = sum_f[15:0];
				2'h1: comb_f = (master_f > aux_f) ? master_f - aux_f : 16'h0000;
				2'h2: comb_f = (aux_f > master_f) ? aux_f - master_f : 16'h0000;
				default: comb_f = master_f;
			endcase
		end
		local_f = comb_f;
	end

	// hand run source: keypad, terminals, RS-485 or card all land on RUN_LOCAL; unused codes give no run
	always @* begin
		case (rsrc_q[3:0])
			4'h0, 4'h1, 4'h2, 4'h5: local_run_en = 1'b1;
			default: local_run_en = 1'b0;
		endcase
	end

	// local/remote switch handling and output selection
	always @(posedge CLOCK) begin
		if (!RESET_N) begin
			FREQ_CMD <= 16'h0000;
			RUN_CMD <= 2'h0;
			DRIVE_STOP <= 1'b0;
		end else begin
			DRIVE_STOP <= (stop_q == `DSP_STOP_MAX) && STOP_KEY;
			case (lr_q)
				`DSP_LR_STOP: begin
					if (lr_switch) begin
						DRIVE_STOP <= 1'b1;
					end
					FREQ_CMD <= remote_q ? FREQ_REMOTE : local_f;
					RUN_CMD <= remote_q ? RUN_REMOTE : (local_run_en ? RUN_LOCAL : 2'h0);
				end
				`DSP_LR_REMOTE: begin
					FREQ_CMD <= FREQ_REMOTE;
					RUN_CMD <= RUN_REMOTE;
				end
				`DSP_LR_LOCAL: begin
					FREQ_CMD <= local_f;
					RUN_CMD <= local_run_en ? RUN_LOCAL : 2'h0;
				end
				`DSP_LR_HOA: begin
					FREQ_CMD <= remote_q ? FREQ_REMOTE : local_f;
					RUN_CMD <= remote_q ? RUN_REMOTE : (local_run_en ? RUN_LOCAL : 2'h0);
				end
				`DSP_LR_FOLLOW: begin
					FREQ_CMD <= remote_q ? FREQ_REMOTE : local_f;
					RUN_CMD <= remote_q ? RUN_REMOTE : (local_run_en ? RUN_LOCAL : 2'h0);
				end
				default: begin
					// codes above four are refused on write, so this only guards a corrupt word
					FREQ_CMD <= 16'h0000;
					RUN_CMD <= 2'h0;
				end
			endcase
		end
	end

	// display and scaling outputs
	always @(posedge CLOCK) begin
		if (!RESET_N) begin
			DEC_PLACES <= 4'h0;
			UNIT_CODE <= 12'h000;
			SCALE_EN <= 1'b0;
			SCALE_MAX <= 16'h0000;
			FILT_CUR <= `DSP_RST_FILT;
			FILT_KPD <= `DSP_RST_FILT;
		end else begin
			DEC_PLACES <= fmt_q[`DSP_DEC_MSB:`DSP_DEC_LSB];
			UNIT_CODE <= fmt_q[`DSP_UNIT_MSB:`DSP_UNIT_LSB];
			SCALE_EN <= (umax_q != 16'h0000);
			SCALE_MAX <= umax_q;
			FILT_CUR <= fcur_q;
			FILT_KPD <= fkpd_q;
		end
	end
endmodule // dsp_source_select

// ===== testbench/dsp_source_select_properties.sv
// bound checks on the register port and the parameter copies
module dsp_props (
	input wire CLOCK,
	input wire RESET_N,
	input wire REG_WR,
	input wire REG_RD,
	input wire [15:0] REG_ADDR,
	input wire [15:0] REG_WDATA,
	input wire [15:0] REG_RDATA,
	input wire REG_ACK,
	input wire REG_ERR,
	input wire [3:0] DEC_PLACES,
	input wire [11:0] UNIT_CODE,
	input wire SCALE_EN,
	input wire [15:0] SCALE_MAX,
	input wire [15:0] FILT_CUR,
	input wire [15:0] FILT_KPD
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] fmt_q;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);
	// last word offered to the format register
	always @(posedge CLOCK) begin
		if (REG_WR && REG_ADDR == 16'h0019) begin
			fmt_q <= REG_WDATA;
		end
	end
	sequence s_wr(a);
		REG_WR && REG_ADDR == a;
	endsequence
	sequence s_ok;
		REG_ACK && !REG_ERR;
	endsequence
	AST_ACK: assert property ((REG_WR || REG_RD) |=> REG_ACK)
		else $error("no answer after request");
	AST_ACK_CAUSE: assert property (REG_ACK |-> $past(REG_WR || REG_RD))
		else $error("answer without request");
	AST_RD_IDLE: assert property (!REG_ACK |-> REG_RDATA == 16'h0000)
		else $error("read data outside answer");
	AST_RO: assert property (REG_WR && (REG_ADDR == 16'h0018 || REG_ADDR == 16'h001B
		|| REG_ADDR == 16'h0032) |=> REG_ACK && REG_ERR)
		else $error("read-only write accepted");
	AST_ERR_ACK: assert property (REG_ERR |-> REG_ACK)
		else $error("error without answer");
	AST_FMT: assert property (s_wr(16'h0019) ##1 s_ok |=> {UNIT_CODE, DEC_PLACES} == fmt_q)
		else $error("format copy wrong");
	AST_FMT_RANGE: assert property (DEC_PLACES <= 4'h3 && UNIT_CODE <= 12'h024)
		else $error("format out of range");
	AST_SCALE: assert property (SCALE_EN == (SCALE_MAX != 16'h0000))
		else $error("scale enable wrong");
	AST_UMAX: assert property (s_wr(16'h001A) ##1 s_ok |=> SCALE_MAX == $past(REG_WDATA, 2))
		else $error("user maximum copy wrong");
	AST_LR_BAD: assert property (REG_WR && REG_ADDR == 16'h001D && REG_WDATA > 16'h0004 |=> REG_ERR)
		else $error("bad switching mode accepted");
	AST_FILT: assert property (FILT_CUR != 16'h0000 && FILT_KPD != 16'h0000)
		else $error("filter time zero");
endmodule // dsp_props

bind dsp_source_select dsp_props chk_i (.CLOCK(CLOCK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_ERR(REG_ERR),
	.DEC_PLACES(DEC_PLACES), .UNIT_CODE(UNIT_CODE), .SCALE_EN(SCALE_EN), .SCALE_MAX(SCALE_MAX),
	.FILT_CUR(FILT_CUR), .FILT_KPD(FILT_KPD));

// ===== testbench/dsp_master_model.sv
// register master that issues one request and collects the answer
module dsp_master_model (
	input wire logic CLOCK,
	input wire logic REG_ACK,
	input wire logic REG_ERR,
	input wire logic [15:0] REG_RDATA,
	output logic REG_WR,
	output logic REG_RD,
	output logic [15:0] REG_ADDR,
	output logic [15:0] REG_WDATA
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ack;
	logic err;
	logic [15:0] rdata;
	initial begin
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = 16'h0000;
		REG_WDATA = 16'h0000;
	end
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge CLOCK);
		REG_WR = w;
		REG_RD = !w;
		REG_ADDR = a;
		REG_WDATA = d;
		@(negedge CLOCK);
		ack = REG_ACK;
		err = REG_ERR;
		rdata = REG_RDATA;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		REG_ADDR = ~a;
		REG_WDATA = ~d;
		// let the parameter copies land
		@(negedge CLOCK);
	endtask
endmodule // dsp_master_model

// ===== testbench/test_dsp_source_select.sv
// self-checking bench for the source select parameter bank
module test_dsp_source_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK = 1'b0;
	logic RESET_N = 1'b0;
	logic REMOTE_SEL = 1'b0;
	logic STOP_KEY = 1'b0;
	logic [15:0] FREQ_MEM_IN = 16'h1234;
	logic [15:0] PROC_VALUE = 16'h4321;
	logic [1:0] RUN_LOCAL = 2'h2;
	logic [1:0] RUN_REMOTE = 2'h1;
	logic [15:0] fs [0:8];
	logic REG_WR, REG_RD, REG_ACK, REG_ERR, SCALE_EN, DRIVE_STOP;
	logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA, FREQ_CMD, SCALE_MAX, FILT_CUR, FILT_KPD;
	logic [1:0] RUN_CMD;
	logic [3:0] DEC_PLACES;
	logic [11:0] UNIT_CODE;
	int fail_count = 0;
	int n_tests = 0;
	always #2.5 CLOCK = ~CLOCK;
	initial for (int i = 0; i < 9; i++) fs[i] = 16'h0100 * 16'(i + 1);
	dsp_source_select dut (.CLOCK, .RESET_N, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .REG_ACK,
		.REG_ERR, .FREQ_MEM_IN, .PROC_VALUE, .REMOTE_SEL, .STOP_KEY, .FREQ_KEYPAD(fs[0]), .FREQ_RS485(fs[1]),
		.FREQ_ANALOG(fs[2]), .FREQ_UPDOWN(fs[3]), .FREQ_PULSE(fs[4]), .FREQ_POT(fs[5]), .FREQ_CARD(fs[6]),
		.FREQ_PID(fs[7]), .FREQ_REMOTE(fs[8]), .RUN_LOCAL, .RUN_REMOTE, .FREQ_CMD, .RUN_CMD, .DRIVE_STOP,
		.DEC_PLACES, .UNIT_CODE, .SCALE_EN, .SCALE_MAX, .FILT_CUR, .FILT_KPD);
	dsp_master_model m (.CLOCK, .REG_ACK, .REG_ERR, .REG_RDATA, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
		m.xfer(1'b1, a, d);
		chk(16'({m.ack, m.err}), 16'({1'b1, e}));
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] d);
		m.xfer(1'b0, a, 16'h0000);
		chk(m.rdata, d);
	endtask
	task automatic t_reset;
		rd(16'h0018, 16'h1234);
		rd(16'h0019, 16'h0000);
		rd(16'h001A, 16'h0000);
		rd(16'h001D, 16'h0004);
		rd(16'h0030, 16'h0064);
		rd(16'h0031, 16'h0064);
	endtask
	task automatic t_ro;
		wr(16'h0018, 16'h0000, 1'b1);
		rd(16'h0018, 16'h1234);
		wr(16'h001B, 16'h0001, 1'b1);
		wr(16'h0032, 16'h0001, 1'b1);
		rd(16'h0032, 16'h0000);
		wr(16'h001C, 16'h0005, 1'b1);
		rd(16'h001C, 16'h0000);
	endtask
	task automatic t_fmt;
		wr(16'h0019, 16'h0250, 1'b1);
		wr(16'h0019, 16'h0004, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(16'h0019, 16'h0240 | 16'(i), 1'b0);
			chk(16'(DEC_PLACES), 16'(i));
		end
		chk(16'(UNIT_CODE), 16'h0024);
		rd(16'h0019, 16'h0243);
	endtask
	task automatic t_scale;
		wr(16'h001A, 16'hFFFF, 1'b0);
		chk(SCALE_MAX, 16'hFFFF);
		chk(16'(SCALE_EN), 16'h0001);
		rd(16'h001B, 16'h4321);
		wr(16'h001A, 16'h0000, 1'b0);
		chk(16'(SCALE_EN), 16'h0000);
		rd(16'h001B, 16'h0000);
	endtask
	task automatic t_src;
		int fc[8] = '{0, 1, 2, 3, 4, 7, 8, 9};
		int rc[4] = '{0, 1, 2, 5};
		foreach (fc[i]) begin
			wr(16'h001E, 16'(fc[i]), 1'b0);
			chk(FREQ_CMD, fs[i]);
		end
		wr(16'h001E, 16'h0005, 1'b1);
		wr(16'h001E, 16'h000A, 1'b1);
		wr(16'h001E, 16'h0006, 1'b0);
		chk(FREQ_CMD, 16'h0000);
		wr(16'h001E, 16'h0002, 1'b0);
		foreach (rc[i]) begin
			wr(16'h001F, 16'(rc[i]), 1'b0);
			chk(16'(RUN_CMD), 16'(RUN_LOCAL));
		end
		wr(16'h001F, 16'h0004, 1'b1);
		wr(16'h001F, 16'h0003, 1'b0);
		chk(16'(RUN_CMD), 16'h0000);
		wr(16'h001F, 16'h0000, 1'b0);
	endtask
	task automatic t_aux;
		int ac[7] = '{1, 2, 3, 4, 5, 7, 8};
		wr(16'h0023, 16'h0006, 1'b0);
		chk(FREQ_CMD, fs[2]);
		foreach (ac[i]) begin
			wr(16'h0023, 16'(ac[i]), 1'b0);
			chk(FREQ_CMD, fs[2] + fs[i]);
		end
		wr(16'h0023, 16'h0009, 1'b1);
		wr(16'h0024, 16'h0002, 1'b0);
		chk(FREQ_CMD, 16'h0400);
		wr(16'h0023, 16'h0001, 1'b0);
		wr(16'h0024, 16'h0001, 1'b0);
		chk(FREQ_CMD, 16'h0200);
		wr(16'h0024, 16'h0003, 1'b1);
		wr(16'h0023, 16'h0000, 1'b0);
		chk(FREQ_CMD, fs[2]);
	endtask
	task automatic t_lr;
		int n;
		wr(16'h001D, 16'h0002, 1'b0);
		chk(FREQ_CMD, fs[8]);
		wr(16'h001D, 16'h0003, 1'b0);
		REMOTE_SEL = 1'b1;
		repeat (6) @(negedge CLOCK);
		chk(FREQ_CMD, fs[2]);
		wr(16'h001D, 16'h0004, 1'b0);
		chk(FREQ_CMD, fs[8]);
		chk(16'(RUN_CMD), 16'(RUN_REMOTE));
		wr(16'h001D, 16'h0001, 1'b0);
		REMOTE_SEL = 1'b0;
		n = 0;
		while (DRIVE_STOP !== 1'b1 && n < 8) begin
			@(negedge CLOCK);
			n++;
		end
		chk(16'(DRIVE_STOP), 16'h0001);
		wr(16'h001D, 16'h0005, 1'b1);
		wr(16'h001D, 16'h0000, 1'b0);
		chk(FREQ_CMD, fs[2]);
	endtask
	task automatic t_stop;
		wr(16'h0020, 16'h0002, 1'b1);
		wr(16'h0020, 16'h0001, 1'b0);
		STOP_KEY = 1'b1;
		repeat (2) @(negedge CLOCK);
		chk(16'(DRIVE_STOP), 16'h0001);
		wr(16'h0020, 16'h0000, 1'b0);
		chk(16'(DRIVE_STOP), 16'h0000);
		STOP_KEY = 1'b0;
	endtask
	task automatic t_filt;
		wr(16'h0030, 16'h0000, 1'b1);
		wr(16'h0031, 16'h0000, 1'b1);
		wr(16'h0030, 16'h0001, 1'b0);
		chk(FILT_CUR, 16'h0001);
		wr(16'h0031, 16'hFFFF, 1'b0);
		chk(FILT_KPD, 16'hFFFF);
	endtask
	task automatic summarize;
		if (fail_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge CLOCK);
		RESET_N = 1'b1;
		t_reset;
		t_ro;
		t_fmt;
		t_scale;
		t_src;
		t_aux;
		t_lr;
		t_stop;
		t_filt;
		summarize;
	end
	initial begin
		#100us;
		fail_count++;
		summarize;
	end
endmodule // test_dsp_source_select
